/* verilog/lstc_params.svh */
// constants of the line scan trigger control block
// assumes: included by bare name from the trigger control module only
`ifndef LSTC_PARAMS_SVH
`define LSTC_PARAMS_SVH
`define LSTC_CLK_PERIOD_NS 100
`define LSTC_NS_PER_S 1_000_000_000
`define LSTC_NS_PER_US 1000
`define LSTC_CLK_HZ (`LSTC_NS_PER_S / `LSTC_CLK_PERIOD_NS)
`define LSTC_CYC_PER_US (`LSTC_NS_PER_US / `LSTC_CLK_PERIOD_NS)
`define LSTC_RESCALE_ONE 1_000_000
`define LSTC_RESCALE_MIN 10_000
`define LSTC_RESCALE_MAX 100_000_000
`define LSTC_SMOOTH_LOG_MIN 4
`define LSTC_SMOOTH_MAX 512
`define LSTC_PERCENT 100
`define LSTC_LINES_MAX 4096
`define LSTC_DIV_BITS 32
`define LSTC_ACC_BITS 48
`endif

/* verilog/lstc_pkg.sv */
// types of the line scan trigger control block
// assumes: nothing beyond the synthesis tool
package lstc_pkg;
	typedef enum logic [2:0] {
		LSTC_FACT_RISE, LSTC_FACT_FALL, LSTC_FACT_ANY,
		LSTC_FACT_HIGH, LSTC_FACT_LOW
	} lstc_frame_act_type;
	typedef enum logic [1:0] {
		LSTC_LACT_RISE, LSTC_LACT_FALL, LSTC_LACT_ANY
	} lstc_line_act_type;
	typedef enum logic [2:0] {
		LSTC_SMOOTH_16, LSTC_SMOOTH_32, LSTC_SMOOTH_64,
		LSTC_SMOOTH_128, LSTC_SMOOTH_256, LSTC_SMOOTH_512
	} lstc_smooth_type;
	typedef enum logic [2:0] {
		LSTC_JOB_RATE_IN, LSTC_JOB_JIT_IN, LSTC_JOB_WIDTH,
		LSTC_JOB_RATE_OUT, LSTC_JOB_JIT_OUT
	} lstc_job_type;
	typedef enum logic {LSTC_SEQ_ISSUE, LSTC_SEQ_WAIT} lstc_seq_type;
	typedef struct packed {
		logic on;
		logic src_b;
		lstc_frame_act_type act;
	} lstc_frame_cfg_type;
	typedef struct packed {
		logic on;
		logic src_b;
		lstc_line_act_type act;
	} lstc_line_cfg_type;
	typedef struct packed {
		logic [31:0] incoming_rate_meas;
		logic [31:0] incoming_rate_peak;
		logic [31:0] incoming_jitter_meas;
		logic [31:0] incoming_pulse_width;
		logic [31:0] converted_rate_meas;
		logic [31:0] converted_jitter_meas;
	} lstc_stats_type;
endpackage

/* verilog/lstc_period_mem.sv */
// period history memory for the trigger smoothing filter
// assumes: one write and one read port, read data one cycle late
`timescale 1ns/10ps
module lstc_period_mem #(
	parameter int W = 24,
	parameter int DEPTH = 512
) (
	input wire logic clk, // system clock
	input wire logic wr_en, // write strobe
	input wire logic [$clog2(DEPTH)-1:0] wr_addr, // write address
	input wire logic [W-1:0] wr_data, // write data
	input wire logic [$clog2(DEPTH)-1:0] rd_addr, // read address
	output logic [W-1:0] rd_data_q // registered read data
);
	logic [W-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data_q <= mem[rd_addr];
	end
endmodule // lstc_period_mem

/* verilog/lstc_divider.sv */
// serial restoring divider, one quotient bit per clock
// assumes: start only while idle, operands stable at start
`timescale 1ns/10ps
module lstc_divider #(
	parameter int W = 32
) (
	input wire logic clk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic start, // begin a division
	input wire logic [W-1:0] num, // dividend
	input wire logic [W-1:0] den, // divisor, nonzero
	output logic [W-1:0] quo_q, // quotient, valid with done_q
	output logic done_q // one-cycle completion pulse
);
	logic [W:0] rem_q, rem_d, shifted, diff;
	logic [W-1:0] den_q, den_d, quo_d;
	logic [$clog2(W):0] cnt_q, cnt_d;
	logic done_d;

	always_comb begin
		rem_d = rem_q;
		den_d = den_q;
		quo_d = quo_q;
		cnt_d = cnt_q;
		done_d = 1'b0;
		shifted = {rem_q[W-1:0], quo_q[W-1]};
		diff = shifted - {1'b0, den_q};
		if (start) begin
			rem_d = '0;
			den_d = den;
			quo_d = num;
			cnt_d = ($clog2(W)+1)'(W);
		end else if (cnt_q != '0) begin
			rem_d = diff[W] ? shifted : diff;
			quo_d = {quo_q[W-2:0], ~diff[W]};
			cnt_d = cnt_q - 1'b1;
			done_d = (cnt_q == 1);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rem_q <= '0;
			den_q <= '0;
			quo_q <= '0;
			cnt_q <= '0;
			done_q <= 1'b0;
		end else begin
			rem_q <= rem_d;
			den_q <= den_d;
			quo_q <= quo_d;
			cnt_q <= cnt_d;
			done_q <= done_d;
		end
	end
endmodule // lstc_divider

/* verilog/lstc_trigger_ctrl.sv */
// frame and line start trigger control with rescaler and statistics
// assumes: inputs synchronous to clk, single 10 MHz clock domain
`timescale 1ns/10ps
`include "lstc_params.svh"
module lstc_trigger_ctrl #(
	parameter int PW = 24,
	parameter int RW = 12,
	parameter int READOUT_CYC = 1,
	parameter int MEM_DEPTH = 512
) (
	input wire logic clk, // 10 MHz clock
	input wire logic nrst, // async reset, active low
	input wire logic acq_start, // acquisition start pulse
	input wire logic acq_stop, // acquisition stop pulse
	input wire logic external_input_a, // external trigger line a
	input wire logic external_input_b, // external trigger line b
	input wire lstc_pkg::lstc_frame_cfg_type frame_cfg, // frame trigger
	input wire lstc_pkg::lstc_line_cfg_type line_cfg, // line trigger
	input wire logic [12:0] lines_per_frame, // lines per frame
	input wire logic [PW-1:0] line_period, // internal period, cycles
	input wire logic [RW-1:0] region_width, // region width, pixels
	input wire logic [PW-1:0] transmit_cycles, // line transmit time
	input wire logic rescale_enable, // rescaler on
	input wire logic [26:0] rescale_factor, // rate in millionths
	input wire lstc_pkg::lstc_smooth_type rescale_smoothing_size, // size
	output logic frame_valid_q, // frame start trigger valid
	output logic line_start_q, // line acquisition start pulse
	output logic frame_done_q, // frame completed pulse
	output logic line_ignored_q, // discarded line trigger pulse
	output lstc_pkg::lstc_stats_type stats_q // trigger statistics
);
	localparam int AW = $clog2(MEM_DEPTH);
	localparam int SW = PW + AW;
	localparam int DW = `LSTC_DIV_BITS;

	if (PW < 8 || PW > 24 || MEM_DEPTH != `LSTC_SMOOTH_MAX ||
		READOUT_CYC < 1) begin : g_bad_param
		$error("lstc_trigger_ctrl: unsupported parameter values");
	end

	// ************************************************
	// input edges
	// ************************************************
	logic a_prev_q, b_prev_q;
	logic fsel, fprev, lsel, lprev, f_rise, f_fall, l_rise, l_fall;
	logic frame_evt, level_mode, level_on, line_evt;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			a_prev_q <= 1'b0;
			b_prev_q <= 1'b0;
		end else begin
			a_prev_q <= external_input_a;
			b_prev_q <= external_input_b;
		end
	end

	always_comb begin
		fsel = frame_cfg.src_b ? external_input_b : external_input_a;
		fprev = frame_cfg.src_b ? b_prev_q : a_prev_q;
		lsel = line_cfg.src_b ? external_input_b : external_input_a;
		lprev = line_cfg.src_b ? b_prev_q : a_prev_q;
		f_rise = fsel & ~fprev;
		f_fall = ~fsel & fprev;
		l_rise = lsel & ~lprev;
		l_fall = ~lsel & lprev;
		level_mode = 1'b0;
		level_on = 1'b0;
		case (frame_cfg.act)
		lstc_pkg::LSTC_FACT_RISE: frame_evt = f_rise;
		lstc_pkg::LSTC_FACT_FALL: frame_evt = f_fall;
		lstc_pkg::LSTC_FACT_ANY: frame_evt = f_rise | f_fall;
		lstc_pkg::LSTC_FACT_HIGH: begin
			frame_evt = f_rise;
			level_mode = 1'b1;
			level_on = fsel;
		end
		lstc_pkg::LSTC_FACT_LOW: begin
			frame_evt = f_fall;
			level_mode = 1'b1;
			level_on = ~fsel;
		end
		default: frame_evt = 1'b0;
		endcase
		case (line_cfg.act)
		lstc_pkg::LSTC_LACT_RISE: line_evt = l_rise;
		lstc_pkg::LSTC_LACT_FALL: line_evt = l_fall;
		lstc_pkg::LSTC_LACT_ANY: line_evt = l_rise | l_fall;
		default: line_evt = 1'b0;
		endcase
	end

	// ************************************************
	// input period, pulse width and smoothing filter
	// ************************************************
	logic [PW-1:0] per_cnt_q, per_cnt_d, in_period_q, in_period_d;
	logic [PW-1:0] wid_cnt_q, wid_cnt_d, width_q, width_d;
	logic seen_q, seen_d, pend_q, pend_d;
	logic [PW-1:0] new_q, new_d, rd_data, old_val, avg;
	logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_addr;
	logic [AW:0] fill_q, fill_d, smooth_n;
	logic [SW-1:0] sum_q, sum_d;
	logic [2:0] sel_q;
	logic [3:0] smooth_sh;
	logic stb, avg_ok;

	always_comb begin
		stb = line_evt & seen_q;
		smooth_sh = 4'(`LSTC_SMOOTH_LOG_MIN) + {1'b0, sel_q};
		smooth_n = (AW+1)'(1) << smooth_sh;
		rd_addr = wr_ptr_q + AW'(pend_q) - AW'(smooth_n);
		old_val = (fill_q >= smooth_n) ? rd_data : '0;
		avg = PW'(sum_q >> smooth_sh);
		avg_ok = (fill_q >= smooth_n) && (avg != '0);
		per_cnt_d = (per_cnt_q == '1) ? per_cnt_q : per_cnt_q + 1'b1;
		in_period_d = in_period_q;
		seen_d = seen_q | line_evt;
		new_d = new_q;
		pend_d = stb;
		if (line_evt) begin
			per_cnt_d = '0;
		end
		if (stb) begin
			in_period_d = per_cnt_q + 1'b1;
			new_d = per_cnt_q + 1'b1;
		end
		wid_cnt_d = lsel ? wid_cnt_q + 1'b1 : '0;
		width_d = l_fall ? wid_cnt_q : width_q;
		sum_d = sum_q;
		fill_d = fill_q;
		wr_ptr_d = wr_ptr_q;
		if (sel_q != rescale_smoothing_size) begin
			sum_d = '0;
			fill_d = '0;
		end else if (pend_q) begin
			sum_d = sum_q + SW'(new_q) - SW'(old_val);
			wr_ptr_d = wr_ptr_q + 1'b1;
			if (fill_q != (AW+1)'(MEM_DEPTH)) begin
				fill_d = fill_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			per_cnt_q <= '0;
			in_period_q <= '0;
			wid_cnt_q <= '0;
			width_q <= '0;
			seen_q <= 1'b0;
			pend_q <= 1'b0;
			new_q <= '0;
			wr_ptr_q <= '0;
			fill_q <= '0;
			sum_q <= '0;
			sel_q <= '0;
		end else begin
			per_cnt_q <= per_cnt_d;
			in_period_q <= in_period_d;
			wid_cnt_q <= wid_cnt_d;
			width_q <= width_d;
			seen_q <= seen_d;
			pend_q <= pend_d;
			new_q <= new_d;
			wr_ptr_q <= wr_ptr_d;
			fill_q <= fill_d;
			sum_q <= sum_d;
			sel_q <= rescale_smoothing_size;
		end
	end

	lstc_period_mem #(
		.W(PW),
		.DEPTH(MEM_DEPTH)
	) u_mem (
		.clk(clk),
		.wr_en(pend_q),
		.wr_addr(wr_ptr_q),
		.wr_data(new_q),
		.rd_addr(rd_addr),
		.rd_data_q(rd_data)
	);

	// ************************************************
	// rescaler
	// ************************************************
	logic [`LSTC_ACC_BITS-1:0] acc_q, acc_d, thr;
	logic [26:0] fct;
	logic resc_q, resc_d, acq_q, acq_d;
	logic [PW-1:0] out_cnt_q, out_cnt_d, out_per_q, out_per_d;
	logic [PW-1:0] out_prev_q, out_prev_d;

	always_comb begin
		fct = rescale_factor;
		if (rescale_factor < 27'(`LSTC_RESCALE_MIN)) begin
			fct = 27'(`LSTC_RESCALE_MIN);
		end else if (rescale_factor > 27'(`LSTC_RESCALE_MAX)) begin
			fct = 27'(`LSTC_RESCALE_MAX);
		end
		thr = `LSTC_ACC_BITS'(avg) * `LSTC_ACC_BITS'(`LSTC_RESCALE_ONE);
		acc_d = '0;
		resc_d = 1'b0;
		if (rescale_enable && avg_ok && acq_q) begin
			if (acc_q >= thr) begin
				acc_d = acc_q - thr + `LSTC_ACC_BITS'(fct);
				resc_d = 1'b1;
			end else begin
				acc_d = acc_q + `LSTC_ACC_BITS'(fct);
			end
		end
		out_cnt_d = (out_cnt_q == '1) ? out_cnt_q : out_cnt_q + 1'b1;
		out_per_d = out_per_q;
		out_prev_d = out_prev_q;
		if (resc_q) begin
			out_cnt_d = '0;
			out_per_d = out_cnt_q + 1'b1;
			out_prev_d = out_per_q;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			acc_q <= '0;
			resc_q <= 1'b0;
			out_cnt_q <= '0;
			out_per_q <= '0;
			out_prev_q <= '0;
		end else begin
			acc_q <= acc_d;
			resc_q <= resc_d;
			out_cnt_q <= out_cnt_d;
			out_per_q <= out_per_d;
			out_prev_q <= out_prev_d;
		end
	end

	// ************************************************
	// frame and line sequencing
	// ************************************************
	logic [PW-1:0] int_cnt_q, int_cnt_d, gap_q, gap_d;
	logic [PW-1:0] min_per, eff_per, readout;
	logic [12:0] line_cnt_q, line_cnt_d, lpf;
	logic ltrig, gap_ok, fv_d, ls_d, fd_d, li_d;

	always_comb begin
		acq_d = (acq_q | acq_start) & ~acq_stop;
		readout = PW'(region_width) * PW'(READOUT_CYC);
		min_per = (transmit_cycles > readout) ? transmit_cycles : readout;
		eff_per = (line_period > min_per) ? line_period : min_per;
		lpf = (lines_per_frame == '0) ? 13'h1 : lines_per_frame;
		if (lpf > 13'(`LSTC_LINES_MAX)) begin
			lpf = 13'(`LSTC_LINES_MAX);
		end
		int_cnt_d = '0;
		if (acq_q && frame_valid_q && !line_cfg.on) begin
			int_cnt_d = (int_cnt_q + 1'b1 >= eff_per) ? '0 :
				int_cnt_q + 1'b1;
		end
		if (line_cfg.on) begin
			ltrig = rescale_enable ? resc_q : line_evt;
		end else begin
			ltrig = acq_q && frame_valid_q && (int_cnt_q == '0);
		end
		gap_ok = (gap_q + 1'b1 >= min_per) || (gap_q == '1);
		ls_d = ltrig && acq_q && frame_valid_q && gap_ok;
		li_d = ltrig && acq_q && !ls_d;
		gap_d = ls_d ? '0 : ((gap_q == '1) ? gap_q : gap_q + 1'b1);
		fd_d = ls_d && (line_cnt_q + 1'b1 == lpf);
		line_cnt_d = line_cnt_q;
		if (!frame_valid_q || fd_d) begin
			line_cnt_d = '0;
		end else if (ls_d) begin
			line_cnt_d = line_cnt_q + 1'b1;
		end
		if (!acq_q) begin
			fv_d = 1'b0;
		end else if (!frame_cfg.on) begin
			fv_d = ~fd_d;
		end else if (level_mode) begin
			fv_d = level_on;
		end else if (frame_valid_q) begin
			fv_d = ~fd_d;
		end else begin
			fv_d = frame_evt;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			acq_q <= 1'b0;
			int_cnt_q <= '0;
			gap_q <= '1;
			line_cnt_q <= '0;
			frame_valid_q <= 1'b0;
			line_start_q <= 1'b0;
			frame_done_q <= 1'b0;
			line_ignored_q <= 1'b0;
		end else begin
			acq_q <= acq_d;
			int_cnt_q <= int_cnt_d;
			gap_q <= gap_d;
			line_cnt_q <= line_cnt_d;
			frame_valid_q <= fv_d;
			line_start_q <= ls_d;
			frame_done_q <= fd_d;
			line_ignored_q <= li_d;
		end
	end

	// ************************************************
	// statistics, one shared divider in round robin
	// ************************************************
	lstc_pkg::lstc_job_type job_q, job_d;
	lstc_pkg::lstc_seq_type seq_q, seq_d;
	lstc_pkg::lstc_stats_type stats_d;
	logic [DW-1:0] num, den, quo, res;
	logic div_start, div_done;

	function automatic logic [DW-1:0] pct(input logic [PW-1:0] x,
		input logic [PW-1:0] ref_val);
		logic [PW-1:0] d;
		d = (x > ref_val) ? x - ref_val : ref_val - x;
		pct = DW'(d) * DW'(`LSTC_PERCENT);
	endfunction

	always_comb begin
		case (job_q)
		lstc_pkg::LSTC_JOB_RATE_IN: begin
			num = DW'(`LSTC_CLK_HZ);
			den = DW'(in_period_q);
		end
		lstc_pkg::LSTC_JOB_JIT_IN: begin
			num = pct(in_period_q, avg);
			den = DW'(avg);
		end
		lstc_pkg::LSTC_JOB_WIDTH: begin
			num = DW'(width_q);
			den = DW'(`LSTC_CYC_PER_US);
		end
		lstc_pkg::LSTC_JOB_RATE_OUT: begin
			num = DW'(`LSTC_CLK_HZ);
			den = DW'(out_per_q);
		end
		default: begin
			num = pct(out_per_q, out_prev_q);
			den = DW'(out_prev_q);
		end
		endcase
		res = (den == '0) ? '0 : quo;
		div_start = (seq_q == lstc_pkg::LSTC_SEQ_ISSUE);
		seq_d = seq_q;
		job_d = job_q;
		stats_d = stats_q;
		case (seq_q)
		lstc_pkg::LSTC_SEQ_ISSUE: seq_d = lstc_pkg::LSTC_SEQ_WAIT;
		lstc_pkg::LSTC_SEQ_WAIT: begin
			if (div_done) begin
				seq_d = lstc_pkg::LSTC_SEQ_ISSUE;
				case (job_q)
				lstc_pkg::LSTC_JOB_RATE_IN: begin
					stats_d.incoming_rate_meas = res;
					if (res > stats_q.incoming_rate_peak) begin
						stats_d.incoming_rate_peak = res;
					end
					job_d = lstc_pkg::LSTC_JOB_JIT_IN;
				end
				lstc_pkg::LSTC_JOB_JIT_IN: begin
					stats_d.incoming_jitter_meas = res;
					job_d = lstc_pkg::LSTC_JOB_WIDTH;
				end
				lstc_pkg::LSTC_JOB_WIDTH: begin
					stats_d.incoming_pulse_width = res;
					job_d = lstc_pkg::LSTC_JOB_RATE_OUT;
				end
				lstc_pkg::LSTC_JOB_RATE_OUT: begin
					stats_d.converted_rate_meas = res;
					job_d = lstc_pkg::LSTC_JOB_JIT_OUT;
				end
				default: begin
					stats_d.converted_jitter_meas = res;
					job_d = lstc_pkg::LSTC_JOB_RATE_IN;
				end
				endcase
			end
		end
		default: seq_d = lstc_pkg::LSTC_SEQ_ISSUE;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			job_q <= lstc_pkg::LSTC_JOB_RATE_IN;
			seq_q <= lstc_pkg::LSTC_SEQ_ISSUE;
			stats_q <= '0;
		end else begin
			job_q <= job_d;
			seq_q <= seq_d;
			stats_q <= stats_d;
		end
	end

	lstc_divider #(
		.W(DW)
	) u_div (
		.clk(clk),
		.nrst(nrst),
		.start(div_start),
		.num(num),
		.den(den),
		.quo_q(quo),
		.done_q(div_done)
	);
endmodule // lstc_trigger_ctrl

/* verification/lstc_trigger_ctrl_checker.sv */
// checker for the trigger control block
// assumes: bound to lstc_trigger_ctrl, one clock domain
`timescale 1ns/10ps
module lstc_trigger_ctrl_checker (
	input wire logic clk, // clock
	input wire logic nrst, // reset, active low
	input wire logic acq_start, // start pulse
	input wire logic acq_stop, // stop pulse
	input wire logic external_input_a, // line a
	input wire lstc_pkg::lstc_frame_cfg_type frame_cfg, // frame config
	input wire logic frame_valid_q, // frame valid
	input wire logic line_start_q, // line pulse
	input wire logic frame_done_q, // frame done pulse
	input wire logic line_ignored_q, // dropped trigger pulse
	input wire lstc_pkg::lstc_stats_type stats_q // statistics
);
	logic on_q;
	logic on_d;
	always_comb begin
		on_d = acq_stop ? 1'b0 : (acq_start ? 1'b1 : on_q);
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			on_q <= 1'b0;
		else
			on_q <= on_d;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// ****************
	// properties
	// ****************
	sequence s_rise_a;
		on_q && !acq_stop && frame_cfg.on && !frame_cfg.src_b &&
		frame_cfg.act == lstc_pkg::LSTC_FACT_RISE &&
		external_input_a && !$past(external_input_a) && !frame_valid_q;
	endsequence
	sequence s_closed;
		##2 !frame_valid_q;
	endsequence
	property p_frame_rise;
		s_rise_a |=> frame_valid_q;
	endproperty
	a_frame_rise: assert property (p_frame_rise)
		else $error("frame rise not taken");
	property p_level_off;
		frame_cfg.on && !frame_cfg.src_b && !external_input_a &&
		frame_cfg.act == lstc_pkg::LSTC_FACT_HIGH |=> !frame_valid_q;
	endproperty
	a_level_off: assert property (p_level_off)
		else $error("level frame valid while input low");
	property p_done_line;
		frame_done_q |-> line_start_q;
	endproperty
	a_done_line: assert property (p_done_line)
		else $error("frame done without line");
	property p_done_drop;
		frame_done_q && frame_cfg.on && frame_cfg.act inside
		{lstc_pkg::LSTC_FACT_RISE, lstc_pkg::LSTC_FACT_FALL,
		lstc_pkg::LSTC_FACT_ANY} |-> !frame_valid_q;
	endproperty
	a_done_drop: assert property (p_done_drop)
		else $error("edge frame still valid after done");
	property p_line_valid;
		line_start_q |-> $past(frame_valid_q);
	endproperty
	a_line_valid: assert property (p_line_valid)
		else $error("line started without frame");
	property p_ign_excl;
		line_ignored_q |-> !line_start_q && $past(on_q);
	endproperty
	a_ign_excl: assert property (p_ign_excl)
		else $error("line both started and dropped");
	property p_stop;
		acq_stop |-> s_closed;
	endproperty
	a_stop: assert property (p_stop)
		else $error("frame valid after stop");
	property p_peak;
		$past(nrst) |-> stats_q.incoming_rate_peak >=
		$past(stats_q.incoming_rate_peak);
	endproperty
	a_peak: assert property (p_peak)
		else $error("peak rate fell");
endmodule // lstc_trigger_ctrl_checker

bind lstc_trigger_ctrl lstc_trigger_ctrl_checker u_chk (.clk(clk),
	.nrst(nrst), .acq_start(acq_start), .acq_stop(acq_stop),
	.external_input_a(external_input_a), .frame_cfg(frame_cfg),
	.frame_valid_q(frame_valid_q), .line_start_q(line_start_q),
	.frame_done_q(frame_done_q), .line_ignored_q(line_ignored_q),
	.stats_q(stats_q));

/* verification/lstc_trig_src.sv */
// external trigger source: level on line a, pulses on line b
// assumes: bench clock, outputs change on falling edges
`timescale 1ns/10ps
module lstc_trig_src (
	input wire logic clk, // bench clock
	input wire logic lvl_a, // wanted level of line a
	input wire logic man_b, // manual level of line b
	input wire logic run_b, // pulse train on line b
	input wire logic [15:0] per_b, // train period, cycles
	input wire logic [15:0] wid_b, // high time, cycles
	output logic line_a, // to line a
	output logic line_b // to line b
);
	logic [15:0] cnt_q;
	initial begin
		cnt_q = 16'h0000;
		line_a = 1'b0;
		line_b = 1'b0;
	end
	always @(negedge clk) begin
		line_a <= lvl_a;
		if (run_b) begin
			// fixed period sets the line rate
			cnt_q <= (cnt_q + 16'h0001 >= per_b) ? 16'h0000 :
				cnt_q + 16'h0001;
			line_b <= (cnt_q < wid_b);
		end else begin
			cnt_q <= 16'h0000;
			line_b <= man_b;
		end
	end
endmodule // lstc_trig_src

/* verification/tb.sv */
// testbench of the trigger control block
// assumes: checker bound, source model drives both lines
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
	n_compared++; \
	if ((g) !== (e)) begin \
		bad_count++; \
		$display("Error %s expected %0d seen %0d", nm, e, g); \
	end \
end
module tb;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic acq_start = 1'b0;
	logic acq_stop = 1'b0;
	logic lvl_a = 1'b0;
	logic man_b = 1'b0;
	logic run_b = 1'b0;
	logic [15:0] per_b = 16'h0064;
	logic [15:0] wid_b = 16'h001e;
	logic line_a;
	logic line_b;
	lstc_pkg::lstc_frame_cfg_type frame_cfg = '0;
	lstc_pkg::lstc_line_cfg_type line_cfg = '0;
	logic [12:0] lpf = 13'h0003;
	logic [23:0] lper = 24'h000005;
	logic [11:0] width = 12'h001;
	logic [23:0] tx = 24'h000001;
	logic resc = 1'b0;
	logic [26:0] factor = 27'h007a120;
	lstc_pkg::lstc_smooth_type smooth = lstc_pkg::LSTC_SMOOTH_16;
	logic fv;
	logic ls;
	logic fd;
	logic li;
	lstc_pkg::lstc_stats_type st;
	int bad_count = 0;
	int n_compared = 0;
	int n_line = 0;
	int n_done = 0;
	int n_ign = 0;
	int ev;
	int tab[3][4] = '{'{5, 1, 1, 5}, '{5, 20, 1, 20}, '{5, 1, 30, 30}};
	always #50 clk = !clk;
	lstc_trig_src u_src (.clk(clk), .lvl_a(lvl_a), .man_b(man_b),
		.run_b(run_b), .per_b(per_b), .wid_b(wid_b), .line_a(line_a),
		.line_b(line_b));
	lstc_trigger_ctrl u_dut (.clk(clk), .nrst(nrst), .acq_start(acq_start),
		.acq_stop(acq_stop), .external_input_a(line_a),
		.external_input_b(line_b), .frame_cfg(frame_cfg),
		.line_cfg(line_cfg), .lines_per_frame(lpf), .line_period(lper),
		.region_width(width), .transmit_cycles(tx), .rescale_enable(resc),
		.rescale_factor(factor), .rescale_smoothing_size(smooth),
		.frame_valid_q(fv), .line_start_q(ls), .frame_done_q(fd),
		.line_ignored_q(li), .stats_q(st));
	always @(posedge clk) begin
		if (ls === 1'b1)
			n_line++;
		if (fd === 1'b1)
			n_done++;
		if (li === 1'b1)
			n_ign++;
	end
	// ****************
	// tasks
	// ****************
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic clr();
		n_line = 0;
		n_done = 0;
		n_ign = 0;
	endtask
	task automatic do_reset();
		nrst <= 1'b0;
		cyc(10);
		nrst <= 1'b1;
		cyc(1);
	endtask
	task automatic pulse(input bit stop);
		@(negedge clk);
		acq_stop <= stop;
		acq_start <= !stop;
		@(negedge clk);
		acq_stop <= 1'b0;
		acq_start <= 1'b0;
	endtask
	task automatic pulse_b();
		man_b <= !man_b;
		cyc(4);
		man_b <= !man_b;
		cyc(4);
	endtask
	task automatic gap(input int e);
		int k;
		k = 0;
		while (ls !== 1'b1 && k < 3000) begin
			@(negedge clk);
			k++;
		end
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (ls !== 1'b1 && k < 3000);
		`CHK("line gap", e, k)
	endtask
	task automatic wait_lines(input int n);
		int k;
		k = 0;
		while (n_line < n && k < 20000) begin
			@(negedge clk);
			k++;
		end
		`CHK("line count", n, n_line)
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#6000000;
		bad_count++;
		$display("Error watchdog expired");
		end_of_test();
	end
	// ****************
	// tests
	// ****************
	initial begin
		do_reset();
		`CHK("reset valid", 0, fv)
		`CHK("reset stats", 0, st)
		for (int i = 0; i < 3; i++) begin
			lper <= 24'(tab[i][0]);
			tx <= 24'(tab[i][1]);
			width <= 12'(tab[i][2]);
			cyc(2);
			clr();
			pulse(0);
			gap(tab[i][3]);
			wait_lines(3);
			`CHK("frames", 1, n_done)
			pulse(1);
			cyc(4);
			`CHK("stopped", 0, fv)
			$display("test internal %0d done", i);
		end
		tx <= 24'h000001;
		width <= 12'h001;
		for (int i = 0; i < 3; i++) begin
			ev = (i == 2) ? 2 : 1;
			lvl_a <= (i == 1);
			man_b <= (i == 1);
			frame_cfg <= '{on: 1'b1, src_b: 1'b0,
				act: lstc_pkg::lstc_frame_act_type'(i)};
			line_cfg <= '{on: 1'b1, src_b: 1'b1,
				act: lstc_pkg::lstc_line_act_type'(i)};
			lpf <= 13'h0002;
			cyc(4);
			clr();
			pulse(0);
			pulse_b();
			`CHK("early drop", ev, n_ign)
			lvl_a <= (i != 1);
			cyc(4);
			`CHK("frame valid", 1, fv)
			repeat (2 / ev) pulse_b();
			`CHK("lines", 2, n_line)
			`CHK("frames", 1, n_done)
			`CHK("closed", 0, fv)
			pulse_b();
			`CHK("late drop", 2 * ev, n_ign)
			pulse(1);
			$display("test edge %0d done", i);
		end
		for (int i = 0; i < 2; i++) begin
			lvl_a <= (i == 1);
			man_b <= 1'b0;
			frame_cfg <= '{on: 1'b1, src_b: 1'b0, act: (i == 1) ?
				lstc_pkg::LSTC_FACT_LOW : lstc_pkg::LSTC_FACT_HIGH};
			line_cfg <= '{on: 1'b1, src_b: 1'b1, act: lstc_pkg::LSTC_LACT_RISE};
			lpf <= 13'h0064;
			cyc(4);
			clr();
			pulse(0);
			pulse_b();
			lvl_a <= (i == 0);
			cyc(4);
			`CHK("level valid", 1, fv)
			pulse_b();
			lvl_a <= (i == 1);
			cyc(4);
			`CHK("level gone", 0, fv)
			pulse_b();
			`CHK("level lines", 1, n_line)
			`CHK("level drops", 2, n_ign)
			pulse(1);
			$display("test level %0d done", i);
		end
		do_reset();
		frame_cfg <= '0;
		lpf <= 13'h1000;
		run_b <= 1'b1;
		pulse(0);
		cyc(3000);
		`CHK("rate", 100000, st.incoming_rate_meas)
		`CHK("peak", 100000, st.incoming_rate_peak)
		`CHK("jitter", 0, st.incoming_jitter_meas)
		`CHK("pulse width", 3, st.incoming_pulse_width)
		per_b <= 16'h00c8;
		cyc(6000);
		`CHK("slow rate", 50000, st.incoming_rate_meas)
		`CHK("kept peak", 100000, st.incoming_rate_peak)
		$display("test statistics done");
		for (int i = 0; i < 2; i++) begin
			smooth <= i ? lstc_pkg::LSTC_SMOOTH_32 : lstc_pkg::LSTC_SMOOTH_16;
			factor <= i ? 27'h01e8480 : 27'h007a120;
			resc <= 1'b1;
			cyc(9000);
			gap(i ? 100 : 400);
			`CHK("out rate", i ? 100000 : 25000, st.converted_rate_meas)
			`CHK("out jitter", 0, st.converted_jitter_meas)
			$display("test rescale %0d done", i);
		end
		end_of_test();
	end
endmodule // tb
